// ===== src/adc_host_end.sv
/*
 * host end: sends frames of whole conversions with a control byte
 * each, gathers results into a result fifo.
 * assumes the converter end sits on the other modport of the link.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_fifo #(
    parameter int WIDTH = adc_pkg::RES_W,
    parameter int DEPTH = adc_pkg::FIFO_DEPTH
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [DEPTH-1:0][WIDTH-1:0] mem, next_mem;
    logic [AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic full, empty, push, pop;

    // pointer difference gives honest full and empty
    always_comb
    begin
        empty = (wr_ptr == rd_ptr);
        full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
        in_ready = !full;
        out_valid = !empty;
        out_data = mem[rd_ptr[AW-1:0]];
        push = in_valid && !full;
        pop = out_ready && !empty;
        next_mem = mem;
        if (push)
        begin
            next_mem[wr_ptr[AW-1:0]] = in_data;
        end
        next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mem <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            mem <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
endmodule

module adc_host_end #(
    parameter int HALF_CYC = adc_pkg::SCLK_HALF_CYC
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // serial link
    adc_link_if.host link,
    // frame request
    input wire logic start,
    input wire logic [adc_pkg::CHAN_W-1:0] chan_sel,
    input wire logic [adc_pkg::COUNT_W-1:0] conv_count,
    output logic busy,
    // results
    output logic res_valid,
    output logic [adc_pkg::RES_W-1:0] res_data,
    input wire logic res_ready
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FINISH} state_t;
    localparam int DW = $clog2(HALF_CYC + 1);

    state_t st, next_st;
    logic cs_n_r, next_cs_n, sclk_r, next_sclk, din_r, next_din;
    logic [DW-1:0] div, next_div;
    logic [adc_pkg::CNT_W-1:0] rcnt, next_rcnt;
    logic [adc_pkg::COUNT_W-1:0] left, next_left;
    logic [adc_pkg::CTRL_BITS-1:0] ctrl, next_ctrl, ctrl_byte;
    logic [adc_pkg::CONV_CYCLES-1:0] shin, next_shin;
    logic pend, next_pend, next_busy, tick, fifo_ready;
    logic [adc_pkg::RES_W-1:0] pend_data, next_pend_data;
    logic [adc_pkg::CNT_W-1:0] rstep;

    assign link.cs_n = cs_n_r;
    assign link.sclk = sclk_r;
    assign link.din = din_r;

    // results wait here, stalling the serial clock when full
    adc_fifo #(.WIDTH(adc_pkg::RES_W), .DEPTH(adc_pkg::FIFO_DEPTH)) result_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(pend),
        .in_data(pend_data),
        .in_ready(fifo_ready),
        .out_valid(res_valid),
        .out_data(res_data),
        .out_ready(res_ready)
    );

    // frame sequencer: clock divider, byte out, result in
    always_comb
    begin
        next_st = st;
        next_cs_n = cs_n_r;
        next_sclk = sclk_r;
        next_din = din_r;
        next_div = div;
        next_rcnt = rcnt;
        next_left = left;
        next_ctrl = ctrl;
        next_shin = shin;
        next_pend = pend && !fifo_ready;
        next_pend_data = pend_data;
        ctrl_byte = '0;
        ctrl_byte[adc_pkg::CHAN_HI:adc_pkg::CHAN_LO] = chan_sel;
        rstep = (rcnt == adc_pkg::CNT_LAST) ? adc_pkg::CNT_FIRST : rcnt + adc_pkg::CNT_FIRST;
        // a waiting result holds the divider, so nothing is ever dropped
        tick = !pend && (div == DW'(HALF_CYC - 1));
        if (st != ST_IDLE && !pend)
        begin
            next_div = tick ? '0 : div + DW'(1);
        end
        case (st)
            ST_IDLE:
            begin
                next_sclk = 1'b1;
                next_cs_n = 1'b1;
                if (start && conv_count != '0)
                begin
                    // select falls with clock high
                    next_st = ST_RUN;
                    next_cs_n = 1'b0;
                    next_ctrl = ctrl_byte;
                    next_din = ctrl_byte[adc_pkg::CTRL_BITS-1];
                    next_left = conv_count;
                    next_rcnt = '0;
                    next_div = '0;
                end
            end
            ST_RUN:
            begin
                if (tick && sclk_r)
                begin
                    // falling edge: present the next control bit
                    next_sclk = 1'b0;
                    if (rcnt == adc_pkg::CNT_LAST)
                    begin
                        next_ctrl = ctrl_byte;
                        next_din = ctrl_byte[adc_pkg::CTRL_BITS-1];
                    end
                    else if (rcnt != '0)
                    begin
                        next_ctrl = {ctrl[adc_pkg::CTRL_BITS-2:0], 1'b0};
                        next_din = ctrl[adc_pkg::CTRL_BITS-2];
                    end
                end
                else if (tick)
                begin
                    // rising edge: sample the result pin
                    next_sclk = 1'b1;
                    next_rcnt = rstep;
                    next_shin = {shin[adc_pkg::CONV_CYCLES-2:0], link.dout};
                    if (rstep == adc_pkg::CNT_LAST)
                    begin
                        next_pend = 1'b1;
                        next_pend_data = {shin[adc_pkg::RES_W-2:0], link.dout};
                        next_left = left - adc_pkg::COUNT_W'(1);
                        if (left == adc_pkg::COUNT_W'(1))
                        begin
                            next_st = ST_FINISH;
                        end
                    end
                end
            end
            ST_FINISH:
            begin
                // half a period after the last rise, release select
                if (tick)
                begin
                    next_cs_n = 1'b1;
                    next_st = ST_IDLE;
                end
            end
            default:
            begin
                next_st = ST_IDLE;
            end
        endcase
        next_busy = (next_st != ST_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st <= ST_IDLE;
            cs_n_r <= 1'b1;
            sclk_r <= 1'b1;
            din_r <= 1'b0;
            div <= '0;
            rcnt <= '0;
            left <= '0;
            ctrl <= '0;
            shin <= '0;
            pend <= 1'b0;
            pend_data <= '0;
            busy <= 1'b0;
        end
        else
        begin
            st <= next_st;
            cs_n_r <= next_cs_n;
            sclk_r <= next_sclk;
            din_r <= next_din;
            div <= next_div;
            rcnt <= next_rcnt;
            left <= next_left;
            ctrl <= next_ctrl;
            shin <= next_shin;
            pend <= next_pend;
            pend_data <= next_pend_data;
            busy <= next_busy;
        end
    end
endmodule
`default_nettype wire

// ===== src/adc_pkg.sv
/*
 * shared constants for the converter serial frame: frame geometry,
 * control byte layout, clock rates and buffer sizes.
 * assumes both ends and the bench refer to these names only.
 */
package adc_pkg;
    // conversion geometry, in serial clock cycles
    localparam int CONV_CYCLES = 16;
    localparam int TRACK_CYCLES = 3;
    localparam int LEAD_ZEROS = 4;
    localparam int CTRL_BITS = 8;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h10;
    localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
    localparam logic [CNT_W-1:0] CNT_HOLD = 5'h04;
    localparam logic [CNT_W-1:0] CNT_CTRL_DONE = 5'h08;

    // result and channel layout
    localparam int RES_W = 12;
    localparam int NUM_CH = 8;
    localparam int CHAN_W = 3;
    localparam int CHAN_HI = 5;
    localparam int CHAN_LO = 3;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;

    // system clock and serial clock timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_HALF_NS = 200;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RATE_MIN_KSPS = 50;
    localparam int RATE_MAX_KSPS = 200;

    // host buffering
    localparam int FIFO_DEPTH = 16;
    localparam int COUNT_W = 8;
endpackage

// ===== src/adc_link_if.sv
/*
 * the four-wire serial link between host and converter.
 * assumes a single system clock; the bench resolves the output pin
 * from dout and dout_oe_n (low while the converter drives).
 */
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe_n;

    modport device (input cs_n, input sclk, input din, output dout, output dout_oe_n);
    modport host (output cs_n, output sclk, output din, input dout, input dout_oe_n);
endinterface
`default_nettype wire

// ===== src/adc_device_end.sv
/*
 * converter end: frame sequencing, track/hold, successive approximation
 * and serial result shifting, all driven by edges seen on the link.
 * assumes link pins are synchronous to clk and sclk is far slower than clk.
 */
// What this block does
// - frame starts at select fall, ends at rise
// - host gives multiples of sixteen rising edges
// - result pin released while select high
// - serial clock ignored while select high
// - first three cycles track selected input
// - thirteen cycles hold, convert and shift
// - four zeros, then result MSB first
// - back-to-back conversions retrack after sixteen edges
// - select falls, clock high: track next fall
// - select falls, clock low: counts as fall
// - simultaneous falls enter track mode
// - first eight rising edges load control byte
// - host sends control byte every conversion
// - first conversion valid, from channel zero
// - straight binary, first step at half code
// - trial word settles to the result
// - sample on rise, update after fall
// - host keeps 50 to 200 ksps; a full result fifo stalls the host clock below 50 ksps
// - channel from control bits five to three
// - continuous while low, idle after sixteenth
`timescale 1ns/1ps
`default_nettype none
module adc_device_end #(
    parameter int NUM_CH = adc_pkg::NUM_CH,
    parameter int RES_W = adc_pkg::RES_W
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // serial link
    adc_link_if.device link,
    // analog inputs, in half-code units
    input wire logic [NUM_CH-1:0][RES_W:0] analog_level,
    // status and results
    output logic tracking,
    output logic powered_down,
    output logic [adc_pkg::CHAN_W-1:0] channel,
    output logic [RES_W-1:0] result,
    output logic result_valid
);
    // track, hold, or powered down between conversions
    typedef enum logic [1:0] {PH_DOWN, PH_TRACK, PH_HOLD} phase_t;

    // registered state and its next values
    phase_t phase, next_phase;
    logic cs_prev, next_cs_prev;
    logic sclk_prev, next_sclk_prev;
    logic [adc_pkg::CNT_W-1:0] fall_cnt, next_fall_cnt;
    logic [adc_pkg::CNT_W-1:0] rise_cnt, next_rise_cnt;
    logic [adc_pkg::CTRL_BITS-1:0] ctrl_shift, next_ctrl_shift;
    logic [adc_pkg::CHAN_W-1:0] next_channel;
    logic [RES_W:0] held, next_held;
    logic [RES_W-1:0] trial, next_trial;
    logic [RES_W-1:0] next_result;
    logic next_result_valid;
    logic dout_r, next_dout;
    logic oe_n_r, next_oe_n;
    logic next_tracking, next_powered_down;

    // edge detection and step bookkeeping
    logic fall_evt, rise_evt;
    logic [adc_pkg::CNT_W-1:0] fall_step, rise_step;
    logic [adc_pkg::CTRL_BITS-1:0] ctrl_word;
    logic [adc_pkg::CNT_W-1:0] bit_idx;
    logic [RES_W-1:0] cand;
    logic keep;

    // pin drivers come straight from flops, one clk behind the pins
    assign link.dout = dout_r;
    assign link.dout_oe_n = oe_n_r;

    // next-state for the whole converter
    always_comb
    begin
        next_cs_prev = link.cs_n;
        next_sclk_prev = link.sclk;
        next_phase = phase;
        next_fall_cnt = fall_cnt;
        next_rise_cnt = rise_cnt;
        next_ctrl_shift = ctrl_shift;
        next_channel = channel;
        next_held = held;
        next_trial = trial;
        next_result = result;
        next_result_valid = 1'b0;
        next_dout = dout_r;
        next_oe_n = link.cs_n;
        // a fall with clock low, or a real clock fall, counts as a falling edge
        fall_evt = !link.cs_n && !link.sclk && (sclk_prev || cs_prev);
        // rising edges only count once select has been low for a cycle
        rise_evt = !link.cs_n && !cs_prev && link.sclk && !sclk_prev;
        // counts wrap after sixteen, so every conversion restarts at one
        fall_step = (fall_cnt == adc_pkg::CNT_LAST) ? adc_pkg::CNT_FIRST : fall_cnt + adc_pkg::CNT_FIRST;
        rise_step = (rise_cnt == adc_pkg::CNT_LAST) ? adc_pkg::CNT_FIRST : rise_cnt + adc_pkg::CNT_FIRST;
        // control byte so far, and the next trial bit, MSB first
        ctrl_word = {ctrl_shift[adc_pkg::CTRL_BITS-2:0], link.din};
        bit_idx = adc_pkg::CNT_LAST - fall_step;
        cand = trial | (RES_W'(1) << bit_idx[3:0]);
        // code t is reached at t - 1/2 code, so compare held+1 against 2*cand in half codes
        keep = ({1'b0, held} + (RES_W+2)'(1)) >= {1'b0, cand, 1'b0};
        if (link.cs_n)
        begin
            // frame over: counters cleared, clock edges ignored
            next_fall_cnt = '0;
            next_rise_cnt = '0;
            next_phase = PH_DOWN;
            next_dout = 1'b0;
        end
        else
        begin
            if (fall_evt)
            begin
                next_fall_cnt = fall_step;
                if (fall_step <= adc_pkg::CNT_HOLD)
                begin
                    next_dout = 1'b0;
                    if (fall_step == adc_pkg::CNT_FIRST)
                    begin
                        next_phase = PH_TRACK;
                        next_trial = '0;
                    end
                    if (fall_step == adc_pkg::CNT_HOLD)
                    begin
                        // sample is taken on the selected input as tracking ends
                        next_held = analog_level[channel];
                        next_phase = PH_HOLD;
                    end
                end
                else
                begin
                    // one charge step decided per falling edge, shown at once
                    next_trial = keep ? cand : trial;
                    next_dout = keep;
                    if (fall_step == adc_pkg::CNT_LAST)
                    begin
                        next_result = keep ? cand : trial;
                        next_result_valid = 1'b1;
                        next_phase = PH_DOWN;
                    end
                end
            end
            if (rise_evt)
            begin
                next_rise_cnt = rise_step;
                if (rise_step <= adc_pkg::CNT_CTRL_DONE)
                begin
                    next_ctrl_shift = ctrl_word;
                end
                if (rise_step == adc_pkg::CNT_CTRL_DONE)
                begin
                    // takes effect at the next conversion's sample
                    next_channel = ctrl_word[adc_pkg::CHAN_HI:adc_pkg::CHAN_LO];
                end
            end
        end
        next_tracking = (next_phase == PH_TRACK);
        next_powered_down = (next_phase == PH_DOWN);
    end

    // registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // idle pin levels, so no false edge follows reset
            phase <= PH_DOWN;
            cs_prev <= 1'b1;
            sclk_prev <= 1'b1;
            fall_cnt <= '0;
            rise_cnt <= '0;
            ctrl_shift <= '0;
            channel <= adc_pkg::CHAN_RESET;
            held <= '0;
            trial <= '0;
            result <= '0;
            result_valid <= 1'b0;
            dout_r <= 1'b0;
            oe_n_r <= 1'b1;
            tracking <= 1'b0;
            powered_down <= 1'b1;
        end
        else
        begin
            // every register takes its next value
            phase <= next_phase;
            cs_prev <= next_cs_prev;
            sclk_prev <= next_sclk_prev;
            fall_cnt <= next_fall_cnt;
            rise_cnt <= next_rise_cnt;
            ctrl_shift <= next_ctrl_shift;
            channel <= next_channel;
            held <= next_held;
            trial <= next_trial;
            result <= next_result;
            result_valid <= next_result_valid;
            dout_r <= next_dout;
            oe_n_r <= next_oe_n;
            tracking <= next_tracking;
            powered_down <= next_powered_down;
        end
    end
endmodule
`default_nettype wire

// ===== verification/adc_link_monitor.sv
/* link monitor: edge counts, framing and output enable on the serial link.
   assumes one clk domain; instantiated beside the link interface. */
`timescale 1ns/1ps
`default_nettype none
module adc_link_monitor (
    // system
    input wire logic clk,
    input wire logic rst,
    // serial link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_n
);
    logic prev_cs, prev_sclk, fall_ev, rise_ev;
    logic [3:0] fcnt, rcnt, next_fcnt, next_rcnt;
    // edges as the converter sees them, both qualified by select
    assign fall_ev = !cs_n && !sclk && (prev_sclk || prev_cs);
    assign rise_ev = !cs_n && !prev_cs && sclk && !prev_sclk;
    // counts wrap at sixteen, so a whole conversion reads back as zero
    always_comb
    begin
        next_fcnt = cs_n ? 4'h0 : fcnt + {3'h0, fall_ev};
        next_rcnt = cs_n ? 4'h0 : rcnt + {3'h0, rise_ev};
    end
    always_ff @(posedge clk)
    begin
        prev_cs <= rst | cs_n;
        prev_sclk <= rst | sclk;
        fcnt <= rst ? 4'h0 : next_fcnt;
        rcnt <= rst ? 4'h0 : next_rcnt;
    end
    default clocking mon_clk @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_oe_follows;
        1'b1 |=> dout_oe_n == $past(cs_n);
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("dout enable not tracking select");
    property p_quiet_idle;
        cs_n |=> !dout;
    endproperty
    a_quiet_idle: assert property (p_quiet_idle) else $error("dout moved while deselected");
    property p_lead_zeros;
        rise_ev && rcnt < 4'h4 |-> !dout;
    endproperty
    a_lead_zeros: assert property (p_lead_zeros) else $error("leading bit not zero");
    property p_whole_frames;
        $rose(cs_n) |-> rcnt == 4'h0 && fcnt == 4'h0;
    endproperty
    a_whole_frames: assert property (p_whole_frames) else $error("frame not whole conversions");
    property p_sclk_parked;
        cs_n |-> sclk;
    endproperty
    a_sclk_parked: assert property (p_sclk_parked) else $error("serial clock low outside frame");
    property p_din_steady;
        rise_ev |-> $stable(din) ##1 $stable(din);
    endproperty
    a_din_steady: assert property (p_din_steady) else $error("din moved around rise");
    property p_dout_steady;
        rise_ev |=> $stable(dout);
    endproperty
    a_dout_steady: assert property (p_dout_steady) else $error("dout moved after rise");
    property p_first_fall;
        $fell(cs_n) |-> sclk ##[1:8] fall_ev;
    endproperty
    a_first_fall: assert property (p_first_fall) else $error("no first fall after select");
    property p_edge_pairs;
        rise_ev |-> fcnt == rcnt + 4'h1;
    endproperty
    a_edge_pairs: assert property (p_edge_pairs) else $error("fall and rise counts apart");
    c_back_to_back: cover property (rise_ev && rcnt == 4'hf ##[1:8] fall_ev);
    c_frame_end: cover property ($rose(cs_n));
    c_result_one: cover property (rise_ev && rcnt > 4'h3 && dout);
endmodule
`default_nettype wire

// ===== verification/testbench.sv
/* self-checking bench: host and converter ends joined by the link,
   random frames with corner levels, result fifo filled and drained.
   assumes the package, link and both ends are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic rst, start, hold;
    logic clk = 1'b0, res_ready = 1'b0, p_cs = 1'b1, p_sclk = 1'b1, free_run = 1'b1;
    logic tracking, powered_down, result_valid, res_valid, busy;
    logic [2:0] chan_sel, prev_ch, channel;
    logic [7:0] conv_count, ctrl;
    logic [7:0][12:0] level;
    logic [11:0] result, res_data;
    logic [15:0] word;
    logic [31:0] rnd, rr = 32'h18;
    logic [11:0] exp_q[$];
    int errors, check_count, wire_i, dev_i, res_i, rise_n, gap, gap_on;
    // sample period bounds in clk cycles
    localparam int gap_min = 1000000 / (adc_pkg::RATE_MAX_KSPS * adc_pkg::CLK_PERIOD_NS);
    localparam int gap_max = 1000000 / (adc_pkg::RATE_MIN_KSPS * adc_pkg::CLK_PERIOD_NS);
    wire dout_pin;
    adc_link_if link ();
    adc_host_end u_adc_host_end (.clk(clk), .rst(rst), .link(link.host), .start(start), .chan_sel(chan_sel),
        .conv_count(conv_count), .busy(busy), .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
    adc_device_end u_adc_device_end (.clk(clk), .rst(rst), .link(link.device), .analog_level(level),
        .tracking(tracking), .powered_down(powered_down), .channel(channel), .result(result),
        .result_valid(result_valid));
    adc_link_monitor u_adc_link_monitor (.clk(clk), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
        .din(link.din), .dout(link.dout), .dout_oe_n(link.dout_oe_n));
    // the result pin floats unless the converter enables it
    assign dout_pin = link.dout_oe_n ? 1'bz : link.dout;
    always #50 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // half-code input: first step at one half code, top code saturates
    function automatic logic [11:0] code_of(input logic [12:0] lvl);
        return (lvl == 13'h1fff) ? 12'hfff : 12'((lvl + 13'h1) >> 1);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        check_count++;
        if (seen !== want)
        begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one frame; the address sent now only steers the following conversion
    task automatic run_frame(input logic [2:0] ch, input logic [7:0] n);
        @(negedge clk);
        check({15'h0, powered_down}, 16'h1, "idle power");
        check({15'h0, dout_pin}, {15'h0, 1'bz}, "pin released");
        chan_sel = ch;
        conv_count = n;
        start = 1'b1;
        for (int k = 0; k < n; k++)
            exp_q.push_back(code_of(level[k == 0 ? prev_ch : ch]));
        prev_ch = ch;
        @(negedge clk);
        start = 1'b0;
        while (busy !== 1'b0)
            @(negedge clk);
        check({13'h0, channel}, {13'h0, ch}, "channel");
    endtask
    // wire watch: gather dout and din at every serial rise of a frame
    always @(posedge clk)
    begin
        p_cs <= link.cs_n;
        p_sclk <= link.sclk;
        gap++;
        if (link.cs_n !== 1'b0)
        begin
            rise_n = 0;
            gap_on = 0;
        end
        else if ((!p_cs && link.sclk && !p_sclk) === 1'b1)
        begin
            rise_n++;
            word = {word[14:0], dout_pin};
            ctrl = {ctrl[6:0], link.din};
            check({15'h0, tracking}, {15'h0, rise_n < 4}, "track state");
            check({15'h0, powered_down}, {15'h0, rise_n == 16}, "power state");
            if (rise_n == 8)
                check({13'h0, ctrl[5:3]}, {13'h0, chan_sel}, "control byte");
            if (rise_n == 16)
            begin
                check(word, {4'h0, exp_q[wire_i]}, "serial word");
                wire_i++;
                rise_n = 0;
                // back-to-back conversions only; a full fifo stretches the period on purpose
                if (gap_on && free_run)
                begin
                    check({15'h0, gap >= gap_min}, 16'h1, "rate too high");
                    check({15'h0, gap <= gap_max}, 16'h1, "rate too low");
                end
                gap = 0;
                gap_on = 1;
            end
        end
        if (result_valid === 1'b1)
        begin
            check({4'h0, result}, {4'h0, exp_q[dev_i]}, "result");
            dev_i++;
        end
        if ((res_valid & res_ready) === 1'b1)
        begin
            check({4'h0, res_data}, {4'h0, exp_q[res_i]}, "fifo word");
            res_i++;
        end
    end
    // drain side stalls at random, or fully while hold is set
    always @(negedge clk)
    begin
        rr = xs(rr);
        res_ready <= !hold && rr[0];
    end
    initial
    begin
        rst = 1'b1;
        start = 1'b0;
        hold = 1'b0;
        chan_sel = 3'h0;
        conv_count = 8'h0;
        prev_ch = 3'h0;
        rnd = 32'h18;
        for (int i = 0; i < 8; i++)
        begin
            rnd = xs(rnd);
            level[i] = rnd[12:0];
        end
        level[0] = 13'h1fff;
        level[3] = 13'h1;
        level[5] = 13'h0;
        level[7] = 13'h1ffe;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        run_frame(3'h3, 8'h1);
        run_frame(3'h5, 8'h3);
        for (int c = 0; c < 8; c++)
            run_frame(c[2:0], 8'h2);
        repeat (6)
        begin
            rnd = xs(rnd);
            level[rnd[2:0]] = rnd[31:19];
            run_frame(rnd[5:3], {6'h0, rnd[9:8]} + 8'h1);
        end
        // eighteen words against a sixteen-deep fifo that nobody drains
        hold = 1'b1;
        free_run = 1'b0;
        fork
            run_frame(3'h6, 8'h12);
            begin
                repeat (1400) @(negedge clk);
                check({15'h0, busy}, 16'h1, "stalled when full");
                hold = 1'b0;
            end
        join
        repeat (100) @(negedge clk);
        check(res_i[15:0], 16'(exp_q.size()), "words drained");
        check(dev_i[15:0], 16'(exp_q.size()), "conversions done");
        tally_and_finish();
    end
    // hang guard, well beyond the expected few thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
